// [bench/lbh_master_model.sv]
// lbh_master_model.sv: external bus master that asks for the local bus
// assumes core_clk timing; want comes from the bench
`timescale 1ns/10ps
module lbh_master_model (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic want,
  input  wire logic bus_hold_grant,
  output logic      hold_request
);
  logic had_q;
  logic yield_q;
  logic lost;
  assign lost = had_q && !bus_hold_grant && hold_request;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      had_q        <= 1'b0;
      yield_q      <= 1'b0;
      hold_request <= 1'b0;
    end else begin
      had_q <= bus_hold_grant;
      // grant taken back early: yield until our own need ends
      if (lost) begin
        yield_q <= 1'b1;
      end else if (!want) begin
        yield_q <= 1'b0;
      end
      hold_request <= want && !yield_q && !lost;
    end
  end
endmodule // lbh_master_model

// [bench/local_bus_hold_and_transceiver_control_test.sv]
// local_bus_hold_and_transceiver_control_test.sv: self-checking bench
// assumes the bus hold block with PS_DIV shortened to 4
`timescale 1ns/10ps
module local_bus_hold_and_transceiver_control_test;
  import lbh_pkg::*;
  typedef struct {logic [1:0] sel; logic [7:0] tog;} lbh_row_t;
  lbh_row_t rows [4] = '{'{2'h0, 8'h20}, '{2'h1, 8'h10}, '{2'h2, 8'h00}, '{2'h3, 8'h00}};
  logic core_clk = 0, reset = 1, want = 0, auto_bnd = 0, cycle_boundary = 0;
  logic cycle_active = 0, cycle_is_write = 0, cycle_xcvr = 0, data_phase = 0;
  logic refresh_request = 0, other_request = 0, strobe_mode_cfg = 0;
  logic [1:0] clock_select_cfg = 2'h0;
  logic hold_request, bus_hold_grant, bus_float, core_may_start, refresh_go;
  logic xcvr_pin_out, xcvr_pin_oe, transceiver_direction, transceiver_direction_oe;
  logic strobe_mode, primary_clock_out, delayed_clock_out, prev, dir_p;
  logic [7:0] n;
  int n_errors = 0, total_checks = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cycle_boundary <= auto_bnd & ~cycle_boundary;
  lbh_master_model master (.core_clk(core_clk), .reset(reset), .want(want),
    .bus_hold_grant(bus_hold_grant), .hold_request(hold_request));
  lbh_bus_hold #(.PS_DIV(4)) dut (.core_clk(core_clk), .reset(reset),
    .hold_request(hold_request), .cycle_boundary(cycle_boundary),
    .cycle_active(cycle_active), .cycle_is_write(cycle_is_write), .cycle_xcvr(cycle_xcvr),
    .data_phase(data_phase), .refresh_request(refresh_request),
    .other_request(other_request), .strobe_mode_cfg(strobe_mode_cfg),
    .clock_select_cfg(clock_select_cfg), .bus_hold_grant(bus_hold_grant),
    .bus_float(bus_float), .core_may_start(core_may_start), .refresh_go(refresh_go),
    .xcvr_pin_out(xcvr_pin_out), .xcvr_pin_oe(xcvr_pin_oe),
    .transceiver_direction(transceiver_direction),
    .transceiver_direction_oe(transceiver_direction_oe), .strobe_mode(strobe_mode),
    .primary_clock_out(primary_clock_out), .delayed_clock_out(delayed_clock_out));
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? bus_hold_grant : k == 1 ? xcvr_pin_out : hold_request;
  endfunction
  task automatic await(input int k, input logic v);
    for (int i = 0; i < 20 && pick(k) !== v; i++) @(negedge core_clk);
    chk(pick(k), v);
    if (pick(k) !== v) close_out();
  endtask
  task automatic toggles(input int c);
    prev = primary_clock_out;
    n = 0;
    repeat (c) begin
      @(negedge core_clk);
      if (primary_clock_out !== prev) n++;
      if (!reset) chk(delayed_clock_out, prev);
      prev = primary_clock_out;
    end
  endtask
  // enable must be off in any cycle where direction flips outside strobe mode
  always @(negedge core_clk) begin
    if (!reset && transceiver_direction_oe === 1'b1 && strobe_mode === 1'b0 &&
        (dir_p ^ transceiver_direction) === 1'b1)
      chk(xcvr_pin_out, 1'b1);
    dir_p = transceiver_direction;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 0;
    foreach (rows[i]) begin
      @(posedge core_clk);
      clock_select_cfg <= rows[i].sel;
      repeat (12) @(negedge core_clk);
      toggles(32);
      chk(n, rows[i].tog);
      if (rows[i].tog == 0) chk(primary_clock_out, 1'b0);
    end
    @(posedge core_clk);
    clock_select_cfg <= 2'h0;
    want <= 1;
    repeat (10) @(negedge core_clk);
    chk(bus_hold_grant, 1'b0);
    auto_bnd = 1;
    await(0, 1'b1);
    chk(bus_float, 1'b1);
    chk(xcvr_pin_oe, 1'b0);
    chk(transceiver_direction_oe, 1'b0);
    toggles(8);
    chk(n, 8'd8);
    @(posedge core_clk);
    want <= 0;
    await(0, 1'b0);
    repeat (4) @(negedge core_clk);
    chk(bus_float, 1'b0);
    @(posedge core_clk);
    refresh_request <= 1;
    other_request <= 1;
    want <= 1;
    repeat (12) @(negedge core_clk);
    chk(bus_hold_grant, 1'b0);
    chk(refresh_go, 1'b1);
    @(posedge core_clk);
    refresh_request <= 0;
    @(negedge core_clk);
    chk(core_may_start, 1'b0);
    await(0, 1'b1);
    chk(core_may_start, 1'b0);
    chk(refresh_go, 1'b0);
    @(posedge core_clk);
    refresh_request <= 1;
    await(0, 1'b0);
    chk(refresh_go, 1'b0);
    await(2, 1'b0);
    repeat (4) @(negedge core_clk);
    chk(refresh_go, 1'b1);
    @(posedge core_clk);
    refresh_request <= 0;
    other_request <= 0;
    want <= 0;
    cycle_active <= 1;
    cycle_xcvr <= 1;
    cycle_is_write <= 1;
    repeat (6) @(negedge core_clk);
    chk(transceiver_direction, 1'b1);
    chk(xcvr_pin_oe, 1'b1);
    await(1, 1'b0);
    @(posedge core_clk);
    cycle_is_write <= 0;
    repeat (6) @(negedge core_clk);
    chk(transceiver_direction, 1'b0);
    @(posedge core_clk);
    cycle_xcvr <= 0;
    repeat (4) @(negedge core_clk);
    repeat (6) begin
      @(negedge core_clk);
      chk(xcvr_pin_out, 1'b1);
    end
    @(posedge core_clk);
    strobe_mode_cfg <= 1;
    data_phase <= 1;
    repeat (6) @(negedge core_clk);
    chk(strobe_mode, 1'b1);
    // strobe follows the data phase alike for reads and writes
    @(posedge core_clk);
    cycle_xcvr <= 1;
    data_phase <= 0;
    repeat (4) @(negedge core_clk);
    chk(xcvr_pin_out, 1'b1);
    @(posedge core_clk);
    data_phase <= 1;
    repeat (2) @(negedge core_clk);
    chk(xcvr_pin_out, 1'b0);
    @(posedge core_clk);
    cycle_is_write <= 1;
    repeat (4) @(negedge core_clk);
    chk(xcvr_pin_out, 1'b0);
    @(posedge core_clk);
    data_phase <= 0;
    repeat (2) @(negedge core_clk);
    chk(xcvr_pin_out, 1'b1);
    chk(core_may_start, 1'b1);
    @(posedge core_clk);
    reset <= 1;
    toggles(8);
    chk(n, 8'd8);
    chk(strobe_mode, 1'b0);
    chk(xcvr_pin_oe, 1'b0);
    chk(transceiver_direction_oe, 1'b0);
    chk(bus_hold_grant, 1'b0);
    close_out();
  end
endmodule // local_bus_hold_and_transceiver_control_test

// [rtl/lbh_bus_hold.sv]
// lbh_bus_hold.sv: local bus hold arbitration and transceiver control
// assumes the core marks cycle boundaries and reports refresh needs on core_clk
//
// Contract
// R01 - master holds request level while it needs bus
// R02 - finish current cycle, then raise grant
// R03 - float bus outputs while granted
// R04 - drop grant when request withdrawn, resume driving
// R05 - drop grant early when refresh needs bus
// R06 - master yields on early grant withdrawal
// R07 - refresh above hold above other requests
// R08 - enable only in memory, io, ack cycles
// R09 - enable off whenever direction changes
// R10 - enable floats in hold and reset
// R11 - direction high sending, floats hold/reset
// R12 - strobe mode writes timed like reads
// R13 - shared pin resets to enable function
// R14 - clock output follows configured rate
// R15 - primary clock runs through reset, hold
// R16 - delayed clock follows same selection
// R17 - sample request per clock, act at boundaries
// R18 - config bit selects enable or strobe
`timescale 1ns/10ps
`include "lbh_consts.svh"
module lbh_bus_hold
  import lbh_pkg::*;
#(
  parameter int PS_DIV = `LBH_PS_DIV_DEFAULT
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        hold_request,
  input  wire logic        cycle_boundary,
  input  wire logic        cycle_active,
  input  wire logic        cycle_is_write,
  input  wire logic        cycle_xcvr,
  input  wire logic        data_phase,
  input  wire logic        refresh_request,
  input  wire logic        other_request,
  input  wire logic        strobe_mode_cfg,
  input  wire logic [1:0]  clock_select_cfg,
  output logic             bus_hold_grant,
  output logic             bus_float,
  output logic             core_may_start,
  output logic             refresh_go,
  output logic             xcvr_pin_out,
  output logic             xcvr_pin_oe,
  output logic             transceiver_direction,
  output logic             transceiver_direction_oe,
  output logic             strobe_mode,
  output logic             primary_clock_out,
  output logic             delayed_clock_out
);
  lbh_state_t state_q;
  lbh_state_t state_d;
  logic       req_s1_q;
  logic       req_s2_q;
  logic       grant_q;
  logic       mode_q;
  logic       dir_q;
  logic       dir_d;
  logic       en_q;
  logic       en_d;
  lbh_clk_if  cif ();

  // hold request is an external pin: two stages first (see R17)
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= hold_request;
      req_s2_q <= req_s1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      LBH_OWN: begin
        // refresh outranks hold; hold outranks the rest (see R07)
        if (req_s2_q && !refresh_request)
          state_d = LBH_DRAIN;
      end
      LBH_DRAIN: begin
        if (!req_s2_q)
          state_d = LBH_OWN;
        else if (cycle_boundary && !refresh_request)
          state_d = LBH_HOLD; // see R02, R17
      end
      LBH_HOLD: begin
        if (!req_s2_q || refresh_request)
          state_d = LBH_RETAKE; // see R04, R05
      end
      LBH_RETAKE: begin
        // wait for master to drop request before driving (see R06)
        if (!req_s2_q)
          state_d = LBH_OWN;
      end
      default: state_d = LBH_OWN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset)
      state_q <= LBH_OWN;
    else
      state_q <= state_d;
  end

  always_ff @(posedge core_clk) begin
    if (reset)
      grant_q <= 1'b0;
    else
      grant_q <= (state_d == LBH_HOLD); // see R02, R04, R05
  end

  assign bus_hold_grant = grant_q;
  // bus stays floated until master has let go (see R03)
  assign bus_float      = (state_q == LBH_HOLD) || (state_q == LBH_RETAKE);
  // arguments, not module reads, so the assign below follows every input
  function automatic logic other_request_blocked(input logic req,
                                                 input logic refr,
                                                 input logic other);
    // others wait while a hold request is pending (see R07)
    return req && !refr && other;
  endfunction

  assign core_may_start = (state_q == LBH_OWN) &&
                          !other_request_blocked(req_s2_q, refresh_request, other_request);
  assign refresh_go     = refresh_request && (state_q == LBH_OWN || state_q == LBH_DRAIN);

  // mode bit clears to enable function (see R13, R18)
  always_ff @(posedge core_clk) begin
    if (reset)
      mode_q <= `LBH_STROBE_MODE_RST;
    else if (cycle_boundary)
      mode_q <= strobe_mode_cfg;
  end
  assign strobe_mode = mode_q;

  always_comb begin
    dir_d = dir_q;
    if (cycle_active)
      dir_d = cycle_is_write; // see R11
    en_d = 1'b0;
    if (cycle_active && cycle_xcvr && (dir_d == dir_q)) begin
      if (mode_q)
        en_d = data_phase;       // strobe same for reads and writes (see R12)
      else
        en_d = 1'b1;             // see R08
    end
    if (dir_d != dir_q)
      en_d = 1'b0;               // see R09
  end

  always_ff @(posedge core_clk) begin
    if (reset || bus_float) begin
      dir_q <= `LBH_DIR_RESET;
      en_q  <= 1'b0;
    end else begin
      dir_q <= dir_d;
      en_q  <= en_d;
    end
  end

  assign xcvr_pin_out             = ~en_q;
  assign xcvr_pin_oe              = !reset && !bus_float; // see R10
  assign transceiver_direction    = dir_q;
  assign transceiver_direction_oe = !reset && !bus_float; // see R11

  assign cif.sel = clock_select_cfg;
  lbh_clkgen #(.PS_DIV(PS_DIV)) u_clkgen (
    .core_clk (core_clk),
    .reset    (reset),
    .cif      (cif)
  );
  assign primary_clock_out = cif.clk_a; // see R15
  assign delayed_clock_out = cif.clk_b; // see R16

  a_grant_after_boundary: assert property (@(posedge core_clk) disable iff (reset) // see R02
    $rose(grant_q) |-> $past(state_q) == LBH_DRAIN && $past(cycle_boundary))
    else $error("grant rose without a cycle boundary");
  a_float_when_grant: assert property (@(posedge core_clk) disable iff (reset) // see R03
    grant_q |-> bus_float)
    else $error("grant without floated bus");
  a_drop_on_release: assert property (@(posedge core_clk) disable iff (reset) // see R04
    grant_q && !req_s2_q |=> !grant_q)
    else $error("grant kept after request withdrawn");
  a_drop_on_refresh: assert property (@(posedge core_clk) disable iff (reset) // see R05
    grant_q && refresh_request |=> !grant_q)
    else $error("grant kept while refresh waits");
  a_no_grant_refresh: assert property (@(posedge core_clk) disable iff (reset) // see R07
    state_q == LBH_DRAIN && refresh_request |=> !grant_q)
    else $error("hold granted over refresh");
  a_enable_cycles: assert property (@(posedge core_clk) disable iff (reset) // see R08
    en_q |-> $past(cycle_active) && $past(cycle_xcvr))
    else $error("enable outside transfer cycle");
  a_enable_dir_change: assert property (@(posedge core_clk) disable iff (reset) // see R09
    $changed(dir_q) |-> !en_q)
    else $error("enable across direction change");
  a_enable_float: assert property (@(posedge core_clk) // see R10
    (reset || bus_float) |-> !xcvr_pin_oe && !transceiver_direction_oe)
    else $error("transceiver pins driven in hold or reset");
  a_mode_reset: assert property (@(posedge core_clk) // see R13
    $past(reset) |-> !mode_q)
    else $error("shared pin not enable after reset");
  sequence s_clock_low_held;
    clock_select_cfg == `LBH_CLKSEL_LOW ##1 clock_select_cfg == `LBH_CLKSEL_LOW;
  endsequence
  a_clock_low: assert property (@(posedge core_clk) disable iff (reset) // see R14
    s_clock_low_held |-> !primary_clock_out)
    else $error("primary clock not held low");
  // clocks are unknown for the first edges of simulation, hence the disable
  a_delayed_follow: assert property (@(posedge core_clk) disable iff (reset) // see R16
    delayed_clock_out == $past(primary_clock_out))
    else $error("delayed clock does not follow");
endmodule // lbh_bus_hold

// [rtl/lbh_clk_if.sv]
// lbh_clk_if.sv: carries clock selection and clock output levels between modules
// assumes both ends run on core_clk
`timescale 1ns/10ps
interface lbh_clk_if;
  import lbh_pkg::*;
  lbh_clksel_t sel;
  logic        clk_a;
  logic        clk_b;
  modport ctrl (output sel, input clk_a, input clk_b);
  modport gen  (input sel, output clk_a, output clk_b);
endinterface

// [rtl/lbh_clkgen.sv]
// lbh_clkgen.sv: primary and delayed clock outputs from core_clk
// assumes a synchronous active-high reset; clocks keep running through it
`timescale 1ns/10ps
`include "lbh_consts.svh"
module lbh_clkgen
  import lbh_pkg::*;
#(
  parameter int PS_DIV = `LBH_PS_DIV_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset,
  lbh_clk_if.gen   cif
);
  logic [7:0] div_q;
  logic       tick;
  logic       ps_q;
  logic       a_q;
  logic       b_q;

  assign tick = (div_q == 8'(PS_DIV / 2 - 1));

  // reset only seeds an unknown divider, so the outputs never stop in reset (see R15)
  always_ff @(posedge core_clk) begin
    if (reset && $isunknown(div_q))
      div_q <= 8'h00;
    else if (tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (reset && $isunknown(ps_q))
      ps_q <= 1'b0;
    else if (tick)
      ps_q <= ~ps_q;
  end

  // full rate is core_clk itself, approximated by a registered toggle (see R14)
  always_ff @(posedge core_clk) begin
    if (reset && $isunknown(a_q)) begin
      a_q <= 1'b0;
    end else begin
      case (cif.sel)
        `LBH_CLKSEL_FULL:  a_q <= ~a_q;
        `LBH_CLKSEL_PSAVE: a_q <= ps_q;
        default:           a_q <= 1'b0;
      endcase
    end
  end

  // one core cycle behind, same selection (see R16)
  always_ff @(posedge core_clk) begin
    b_q <= a_q;
  end

  assign cif.clk_a = a_q;
  assign cif.clk_b = b_q;
endmodule // lbh_clkgen

// [rtl/lbh_consts.svh]
// lbh_consts.svh: timing and reset constants for the local bus hold block
// assumes inclusion by the package and the block files only
`ifndef LBH_CONSTS_SVH
`define LBH_CONSTS_SVH
`define LBH_PS_DIV_DEFAULT   8
`define LBH_CLKSEL_FULL      2'h0
`define LBH_CLKSEL_PSAVE     2'h1
`define LBH_CLKSEL_LOW       2'h2
`define LBH_CLKSEL_RESET     2'h0
`define LBH_STROBE_MODE_RST  1'b0
`define LBH_DIR_RESET        1'b0
`endif

// [rtl/lbh_pkg.sv]
// lbh_pkg.sv: types shared by the bus hold block and its clock generator
// assumes lbh_consts.svh is on the include path
package lbh_pkg;
  `include "lbh_consts.svh"
  typedef enum logic [1:0] {
    LBH_OWN    = 2'h0,
    LBH_DRAIN  = 2'h1,
    LBH_HOLD   = 2'h3,
    LBH_RETAKE = 2'h2
  } lbh_state_t;
  typedef logic [1:0] lbh_clksel_t;
endpackage
